/* File: include/ldd_cfg_pkg.sv */
package ldd_cfg_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CH2_CTRL = 8'h18;
   localparam logic [7:0] ADDR_REF_LO   = 8'h19;
   localparam logic [7:0] ADDR_CH2_SEL  = 8'h1a;
   localparam logic [7:0] ADDR_CONV     = 8'h1b;
   localparam logic [7:0] ADDR_MODE     = 8'h1c;
   localparam logic [7:0] ADDR_MASK     = 8'h1d;

   // field positions inside their byte
   localparam int REF_HI_POS   = 0;
   localparam int SAT_THR_POS  = 2;
   localparam int COMP_POS     = 4;
   localparam int RANGE_POS    = 4;
   localparam int MEAS_POS     = 6;
   localparam int CONV_POS     = 0;
   localparam int COMBINE_POS  = 6;
   localparam int MODE_POS     = 0;

   // field widths
   localparam int REF_W  = 10;
   localparam int CONV_W = 6;
   localparam int COMP_W = 3;

   // reset values
   localparam logic [9:0] REF_RST     = 10'h000;
   localparam logic [9:0] REF_MAX     = 10'h3ff;
   localparam logic [1:0] SAT_THR_RST = 2'h0;
   localparam logic [2:0] COMP_RST    = 3'h3;
   localparam logic       RANGE_RST   = 1'h0;
   localparam logic       MEAS_RST    = 1'h0;
   localparam logic [5:0] CONV_RST    = 6'h02;
   localparam logic       COMBINE_RST = 1'h0;
   localparam logic [7:0] CTL_RST     = 8'h0e;

   typedef enum logic [1:0] {
      MODE_BAD_LO  = 2'b00,
      MODE_OPERATE = 2'b01,
      MODE_CONFIG  = 2'b10,
      MODE_BAD_HI  = 2'b11
   } mode_t;

   localparam mode_t MODE_RST = MODE_OPERATE;

   // saturation threshold codes: 0.5 V, 0.8 V, 1.0 V, 1.2 V
   typedef enum logic [1:0] {
      SAT_0V5 = 2'b00,
      SAT_0V8 = 2'b01,
      SAT_1V0 = 2'b10,
      SAT_1V2 = 2'b11
   } sat_thr_t;

   typedef struct packed {
      logic [9:0] ch2_reference_code;
      sat_thr_t   ch2_saturation_threshold;
      logic [2:0] ch2_loop_comp;
      logic       ch2_current_range;
      logic       ch2_measure_point_select;
      logic [5:0] converter_ctrl_current;
      logic       channel_combine;
   } cfg_t;

   // same bit order as the mask register byte
   typedef struct packed {
      logic osc_error_simulate;
      logic ch2_overcurrent_simulate;
      logic ch1_overcurrent_simulate;
      logic overtemp_simulate;
      logic ch2_saturation_mask;
      logic ch1_saturation_mask;
      logic monitor_event_mask;
      logic osc_error_mask;
   } evt_ctrl_t;

   typedef struct packed {
      logic osc_error;
      logic ch2_overcurrent;
      logic ch1_overcurrent;
      logic overtemp;
      logic ch2_saturation_event;
      logic ch1_saturation_event;
      logic ch2_monitor_event;
      logic ch1_monitor_event;
   } evt_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage : ldd_cfg_pkg

/* File: hdl/level_sync.sv */
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // asynchronous levels in, filtered levels out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [W-1:0] out_next;

   generate
      if (W < 1) begin : g_bad_w
         $error("level_sync: W must be at least 1");
      end
   endgenerate

   // a bit changes once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_comb begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         out_reg <= '0;
      end else begin
         s1_reg  <= async_in;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign sync_out = out_reg;

endmodule : level_sync

/* File: hdl/laser_driver_general_config_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - channel 2 reference is a 10-bit log code, 0x000 min to 0x3FF max.
// - channel 2 range bit: 0 high current range, 1 low current range.
// - channel 2 measure bit: 0 monitor pad force, 1 internal resistor sense.
// - monitor mask 0 lets both monitor events reach fault; 1 suppresses them.
// - 6-bit converter current, 0x00 none, 0x3F maximum, resets to 0x02.
// - combine 0 independent channels; 1 channel 2 transistor parallels channel 1.
// - mode 01 applies configuration transparently; mode 10 holds applied configuration.
// - mode codes 00 and 11 are illegal and flag a memory error.
// - oscillator mask 0 passes oscillator error to fault, 1 blocks; resets 0.
// - per-channel saturation masks, 0 forward, 1 block; both reset to 1.
// - overtemperature simulate bit at 1 acts as a real overtemperature event.
// - per-channel overcurrent simulate bits at 1 inject an overcurrent event.
// - oscillator simulate bit at 1 injects an oscillator error event.
// - channel 2 saturation threshold code selects 0.5, 0.8, 1.0 or 1.2 V.
module laser_driver_general_config_regs (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // register port from the serial engine
   input  wire ldd_cfg_pkg::reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   // raw events from the analog side
   input  wire ldd_cfg_pkg::evt_t     raw_events,
   // applied configuration to the analog side
   output ldd_cfg_pkg::cfg_t          applied_cfg,
   output ldd_cfg_pkg::mode_t         operation_config_mode,
   output ldd_cfg_pkg::evt_t          active_events,
   // status
   output logic                       memory_error,
   output logic                       fault_output_n
);
   import ldd_cfg_pkg::*;

   cfg_t      cfg_reg, cfg_next;
   cfg_t      applied_reg, applied_next;
   mode_t     mode_reg, mode_next;
   evt_ctrl_t ctl_reg, ctl_next;
   logic [7:0] rdata_reg, rdata_next;
   evt_t      ev_sync;
   evt_t      evt_reg, evt_next;
   logic      mem_err_reg, mem_err_next;
   logic      fault_n_reg, fault_n_next;
   logic      fault_any;

   function automatic logic mode_illegal(input mode_t m);
      return (m == MODE_BAD_LO) || (m == MODE_BAD_HI);
   endfunction : mode_illegal

   level_sync #(
      .W ($bits(evt_t))
   ) u_evt_sync (
      .clk      (clk),
      .srst     (srst),
      .async_in (raw_events),
      .sync_out (ev_sync)
   );

   // register writes and reads
   always_comb begin
      cfg_next   = cfg_reg;
      mode_next  = mode_reg;
      ctl_next   = ctl_reg;
      rdata_next = rdata_reg;
      if (reg_req.wr) begin
         case (reg_req.addr)
            ADDR_CH2_CTRL: begin
               cfg_next.ch2_reference_code[9:8] = reg_req.wdata[REF_HI_POS +: 2];
               cfg_next.ch2_saturation_threshold =
                  sat_thr_t'(reg_req.wdata[SAT_THR_POS +: 2]);
               cfg_next.ch2_loop_comp = reg_req.wdata[COMP_POS +: COMP_W];
            end
            ADDR_REF_LO: begin
               cfg_next.ch2_reference_code[7:0] = reg_req.wdata;
            end
            ADDR_CH2_SEL: begin
               cfg_next.ch2_current_range = reg_req.wdata[RANGE_POS];
               cfg_next.ch2_measure_point_select = reg_req.wdata[MEAS_POS];
            end
            ADDR_CONV: begin
               cfg_next.converter_ctrl_current = reg_req.wdata[CONV_POS +: CONV_W];
               cfg_next.channel_combine = reg_req.wdata[COMBINE_POS];
            end
            ADDR_MODE: begin
               mode_next = mode_t'(reg_req.wdata[MODE_POS +: 2]);
            end
            ADDR_MASK: begin
               ctl_next = evt_ctrl_t'(reg_req.wdata);
            end
            default: begin
               cfg_next = cfg_reg;
            end
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            ADDR_CH2_CTRL: begin
               rdata_next = {1'b0, cfg_reg.ch2_loop_comp, cfg_reg.ch2_saturation_threshold,
                             cfg_reg.ch2_reference_code[9:8]};
            end
            ADDR_REF_LO: begin
               rdata_next = cfg_reg.ch2_reference_code[7:0];
            end
            ADDR_CH2_SEL: begin
               rdata_next = {1'b0, cfg_reg.ch2_measure_point_select, 1'b0,
                             cfg_reg.ch2_current_range, 4'h0};
            end
            ADDR_CONV: begin
               rdata_next = {1'b0, cfg_reg.channel_combine, cfg_reg.converter_ctrl_current};
            end
            ADDR_MODE: begin
               rdata_next = {6'h00, mode_reg};
            end
            ADDR_MASK: begin
               rdata_next = ctl_reg;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   // applied configuration and events
   always_comb begin
      applied_next = (mode_reg == MODE_OPERATE) ? cfg_reg : applied_reg;
      mem_err_next = mode_illegal(mode_reg);
      evt_next = ev_sync;
      evt_next.overtemp = ev_sync.overtemp | ctl_reg.overtemp_simulate;
      evt_next.ch1_overcurrent = ev_sync.ch1_overcurrent | ctl_reg.ch1_overcurrent_simulate;
      evt_next.ch2_overcurrent = ev_sync.ch2_overcurrent | ctl_reg.ch2_overcurrent_simulate;
      evt_next.osc_error = ev_sync.osc_error | ctl_reg.osc_error_simulate;
      fault_any = evt_next.overtemp | evt_next.ch1_overcurrent | evt_next.ch2_overcurrent
                | mem_err_reg
                | (evt_next.osc_error & ~ctl_reg.osc_error_mask)
                | ((ev_sync.ch1_monitor_event | ev_sync.ch2_monitor_event)
                   & ~ctl_reg.monitor_event_mask)
                | (ev_sync.ch1_saturation_event & ~ctl_reg.ch1_saturation_mask)
                | (ev_sync.ch2_saturation_event & ~ctl_reg.ch2_saturation_mask);
      fault_n_next = ~fault_any;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_reg     <= '{REF_RST, sat_thr_t'(SAT_THR_RST), COMP_RST, RANGE_RST, MEAS_RST,
                          CONV_RST, COMBINE_RST};
         applied_reg <= '{REF_RST, sat_thr_t'(SAT_THR_RST), COMP_RST, RANGE_RST, MEAS_RST,
                          CONV_RST, COMBINE_RST};
         mode_reg    <= MODE_RST;
         ctl_reg     <= evt_ctrl_t'(CTL_RST);
         rdata_reg   <= 8'h00;
         evt_reg     <= '0;
         mem_err_reg <= 1'b0;
         fault_n_reg <= 1'b1;
      end else begin
         cfg_reg     <= cfg_next;
         applied_reg <= applied_next;
         mode_reg    <= mode_next;
         ctl_reg     <= ctl_next;
         rdata_reg   <= rdata_next;
         evt_reg     <= evt_next;
         mem_err_reg <= mem_err_next;
         fault_n_reg <= fault_n_next;
      end
   end

   assign reg_rdata             = rdata_reg;
   assign applied_cfg           = applied_reg;
   assign operation_config_mode = mode_reg;
   assign active_events         = evt_reg;
   assign memory_error          = mem_err_reg;
   assign fault_output_n        = fault_n_reg;

   mode_err_a: assert property (
      @(posedge clk) disable iff (srst)
      mode_illegal(mode_reg) |=> memory_error ##1 !fault_output_n)
      else $error("illegal mode not flagged");

   apply_hold_a: assert property (
      @(posedge clk) disable iff (srst)
      (mode_reg == MODE_CONFIG) |=> applied_cfg == $past(applied_cfg))
      else $error("applied configuration changed in configuration mode");

   apply_track_a: assert property (
      @(posedge clk) disable iff (srst)
      (mode_reg == MODE_OPERATE) |=> applied_cfg == $past(cfg_reg))
      else $error("applied configuration not tracking in operation mode");

   reset_vals_a: assert property (
      @(posedge clk)
      srst |=> (applied_cfg.converter_ctrl_current == CONV_RST)
               && ctl_reg.ch1_saturation_mask && ctl_reg.ch2_saturation_mask
               && !ctl_reg.osc_error_mask && (operation_config_mode == MODE_OPERATE))
      else $error("wrong reset values");

   sat_fault_a: assert property (
      @(posedge clk) disable iff (srst)
      (ev_sync.ch2_saturation_event && !ctl_reg.ch2_saturation_mask) |=> !fault_output_n)
      else $error("unmasked saturation did not assert fault");

   mon_fault_a: assert property (
      @(posedge clk) disable iff (srst)
      (ev_sync.ch1_monitor_event && !ctl_reg.monitor_event_mask) |=> !fault_output_n)
      else $error("unmasked monitor event did not assert fault");

   ovt_sim_a: assert property (
      @(posedge clk) disable iff (srst)
      ctl_reg.overtemp_simulate |=> active_events.overtemp && !fault_output_n)
      else $error("simulated overtemperature missing");

   osc_sim_a: assert property (
      @(posedge clk) disable iff (srst)
      (ctl_reg.osc_error_simulate && !ctl_reg.osc_error_mask) |=>
         active_events.osc_error && !fault_output_n)
      else $error("simulated oscillator error missing");

   ovc_sim_a: assert property (
      @(posedge clk) disable iff (srst)
      ctl_reg.ch2_overcurrent_simulate |=> active_events.ch2_overcurrent)
      else $error("simulated overcurrent missing");

   quiet_fault_a: assert property (
      @(posedge clk) disable iff (srst)
      (ev_sync == '0 && ctl_reg == evt_ctrl_t'(CTL_RST) && !memory_error) |=> fault_output_n)
      else $error("fault asserted with no event");

   mask_read_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.wr && reg_req.addr == ADDR_MASK) ##1 (reg_req.rd && reg_req.addr == ADDR_MASK
         && !reg_req.wr) |=> reg_rdata == $past(reg_req.wdata, 2))
      else $error("mask register read back mismatch");

   conv_read_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == ADDR_CONV) |=>
         reg_rdata[5:0] == $past(cfg_reg.converter_ctrl_current) && reg_rdata[7] == 1'b0)
      else $error("converter current read back mismatch");

   unmapped_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.rd && reg_req.addr > ADDR_MASK) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   unmapped_wr_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.wr && (reg_req.addr < ADDR_CH2_CTRL || reg_req.addr > ADDR_MASK)) |=>
         $stable(cfg_reg) && $stable(ctl_reg) && $stable(mode_reg))
      else $error("write to unmapped address changed a register");

   ref_write_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.wr && reg_req.addr == ADDR_REF_LO) |=>
         cfg_reg.ch2_reference_code[7:0] == $past(reg_req.wdata))
      else $error("reference code low byte not stored");

   thr_write_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.wr && reg_req.addr == ADDR_CH2_CTRL) |=>
         cfg_reg.ch2_saturation_threshold == $past(reg_req.wdata[SAT_THR_POS +: 2])
         && cfg_reg.ch2_reference_code[9:8] == $past(reg_req.wdata[REF_HI_POS +: 2]))
      else $error("threshold or reference high bits not stored");

   sel_read_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.rd && reg_req.addr == ADDR_CH2_SEL) |=>
         reg_rdata[RANGE_POS] == $past(cfg_reg.ch2_current_range)
         && reg_rdata[MEAS_POS] == $past(cfg_reg.ch2_measure_point_select)
         && reg_rdata[7] == 1'b0 && reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0)
      else $error("range or measure bit read back mismatch");

   conv_write_a: assert property (
      @(posedge clk) disable iff (srst)
      (reg_req.wr && reg_req.addr == ADDR_CONV) |=>
         cfg_reg.channel_combine == $past(reg_req.wdata[COMBINE_POS])
         && cfg_reg.converter_ctrl_current == $past(reg_req.wdata[CONV_POS +: CONV_W]))
      else $error("converter current or combine bit not stored");

   mode_legal_a: assert property (
      @(posedge clk) disable iff (srst)
      !mode_illegal(mode_reg) |=> !memory_error)
      else $error("memory error without illegal mode");

   ovc1_sim_a: assert property (
      @(posedge clk) disable iff (srst)
      ctl_reg.ch1_overcurrent_simulate |=> active_events.ch1_overcurrent && !fault_output_n)
      else $error("simulated channel 1 overcurrent missing");

   masked_quiet_a: assert property (
      @(posedge clk) disable iff (srst)
      (ctl_reg.osc_error_mask && ctl_reg.monitor_event_mask && ctl_reg.ch1_saturation_mask
         && ctl_reg.ch2_saturation_mask && !ctl_reg.overtemp_simulate
         && !ctl_reg.ch1_overcurrent_simulate && !ctl_reg.ch2_overcurrent_simulate
         && !ev_sync.overtemp && !ev_sync.ch1_overcurrent && !ev_sync.ch2_overcurrent
         && !memory_error) |=> fault_output_n)
      else $error("masked event reached the fault output");

endmodule : laser_driver_general_config_regs

/* File: testbench/laser_driver_general_config_regs_test.sv */
`timescale 1ns/1ps
module laser_driver_general_config_regs_test;
   import ldd_cfg_pkg::*;

   logic       clk;
   logic       srst;
   reg_req_t   reg_req;
   logic [7:0] reg_rdata;
   evt_t       raw_events;
   cfg_t       applied_cfg;
   mode_t      operation_config_mode;
   evt_t       active_events;
   logic       memory_error;
   logic       fault_output_n;
   int         n_fail;
   int         n_compared;
   int         i;

   laser_driver_general_config_regs uut (
      .clk                   (clk),
      .srst                  (srst),
      .reg_req               (reg_req),
      .reg_rdata             (reg_rdata),
      .raw_events            (raw_events),
      .applied_cfg           (applied_cfg),
      .operation_config_mode (operation_config_mode),
      .active_events         (active_events),
      .memory_error          (memory_error),
      .fault_output_n        (fault_output_n)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cycles

   // one-cycle write pulse, then an idle cycle
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      reg_req.addr  = addr;
      reg_req.wdata = data;
      reg_req.wr    = 1'b1;
      @(posedge clk);
      #1 reg_req.wr = 1'b0;
      wait_cycles(1);
   endtask : write_reg

   task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
      reg_req.addr = addr;
      reg_req.rd   = 1'b1;
      @(posedge clk);
      #1 reg_req.rd = 1'b0;
      wait_cycles(1);
      check(what, {24'h0, exp}, {24'h0, reg_rdata});
   endtask : read_check

   // write, then read the same address in the very next cycle
   task automatic write_read(input logic [7:0] addr, input logic [7:0] data,
                             input logic [7:0] exp, input string what);
      reg_req.addr  = addr;
      reg_req.wdata = data;
      reg_req.wr    = 1'b1;
      @(posedge clk);
      #1 reg_req.wr = 1'b0;
      reg_req.rd    = 1'b1;
      @(posedge clk);
      #1 reg_req.rd = 1'b0;
      wait_cycles(1);
      check(what, {24'h0, exp}, {24'h0, reg_rdata});
   endtask : write_read

   initial begin
      #100000;
      n_fail++;
      $display("wrong value watchdog expected done seen hang");
      report_and_stop();
   end

   initial begin
      n_fail     = 0;
      n_compared = 0;
      srst       = 1'b1;
      reg_req    = '0;
      raw_events = '0;
      repeat (16) @(posedge clk);
      #1 srst = 1'b0;
      // reset state of every register
      read_check(ADDR_CH2_CTRL, {1'b0, COMP_RST, SAT_THR_RST, REF_RST[9:8]}, "ch2_ctrl");
      read_check(ADDR_REF_LO, REF_RST[7:0], "ref_lo");
      read_check(ADDR_CH2_SEL, 8'h00, "ch2_sel");
      read_check(ADDR_CONV, {2'h0, CONV_RST}, "conv");
      read_check(ADDR_MODE, {6'h0, MODE_RST}, "mode");
      read_check(ADDR_MASK, CTL_RST, "mask");
      check("mask_osc", 32'h0, {31'h0, uut.reg_rdata[0]});
      check("cfg_rst", {8'h0, REF_RST, SAT_THR_RST, COMP_RST, RANGE_RST, MEAS_RST,
                        CONV_RST, COMBINE_RST}, {8'h0, applied_cfg});
      check("fault_rst", 32'h1, {31'h0, fault_output_n});
      // threshold codes and reference code maximum
      for (i = 0; i < 4; i++) begin
         write_reg(ADDR_CH2_CTRL, {1'b0, 3'h5, i[1:0], 2'h3});
         read_check(ADDR_CH2_CTRL, {1'b0, 3'h5, i[1:0], 2'h3}, "thr_rd");
         check("thr_cfg", i, {30'h0, applied_cfg.ch2_saturation_threshold});
      end
      write_reg(ADDR_REF_LO, 8'hff);
      wait_cycles(2);
      check("ref_max", {22'h0, REF_MAX}, {22'h0, applied_cfg.ch2_reference_code});
      read_check(ADDR_REF_LO, 8'hff, "ref_lo_rd");
      // range and measure bits, reserved bits read zero
      write_reg(ADDR_CH2_SEL, 8'hff);
      read_check(ADDR_CH2_SEL, 8'h50, "ch2_sel_rd");
      check("range", 32'h1, {31'h0, applied_cfg.ch2_current_range});
      check("meas", 32'h1, {31'h0, applied_cfg.ch2_measure_point_select});
      write_reg(ADDR_CH2_SEL, 8'h00);
      wait_cycles(2);
      check("range0", 32'h0, {31'h0, applied_cfg.ch2_current_range});
      // converter current maximum and combine
      write_reg(ADDR_CONV, 8'h7f);
      read_check(ADDR_CONV, 8'h7f, "conv_rd");
      check("conv_max", 32'h3f, {26'h0, applied_cfg.converter_ctrl_current});
      check("combine", 32'h1, {31'h0, applied_cfg.channel_combine});
      // configuration mode holds the applied values
      write_reg(ADDR_MODE, 8'h02);
      write_reg(ADDR_CONV, 8'h40);
      wait_cycles(3);
      check("mode_cfg", {30'h0, MODE_CONFIG}, {30'h0, operation_config_mode});
      check("hold_conv", 32'h3f, {26'h0, applied_cfg.converter_ctrl_current});
      check("err_cfg", 32'h0, {31'h0, memory_error});
      // both illegal codes raise the error
      for (i = 0; i < 4; i = i + 3) begin
         write_reg(ADDR_MODE, i[7:0]);
         wait_cycles(3);
         check("mem_err", 32'h1, {31'h0, memory_error});
         check("err_fault", 32'h0, {31'h0, fault_output_n});
         check("hold_bad", 32'h3f, {26'h0, applied_cfg.converter_ctrl_current});
         read_check(ADDR_MODE, i[7:0], "mode_rd");
      end
      write_reg(ADDR_MODE, 8'h01);
      wait_cycles(3);
      check("apply_conv", 32'h0, {26'h0, applied_cfg.converter_ctrl_current});
      check("err_clr", 32'h0, {31'h0, memory_error});
      check("fault_clr", 32'h1, {31'h0, fault_output_n});
      // each raw event unmasked, then with every mask set
      for (i = 0; i < 16; i++) begin
         write_reg(ADDR_MASK, (i < 8) ? 8'h00 : 8'h0f);
         raw_events = evt_t'(8'h01 << (i % 8));
         wait_cycles(8);
         check("act_evt", 32'h1 << (i % 8), {24'h0, active_events});
         check("evt_fault", (i >= 8 && ((i % 8) < 4 || (i % 8) == 7)) ? 32'h1 : 32'h0,
               {31'h0, fault_output_n});
         raw_events = '0;
         wait_cycles(8);
      end
      // simulate bits inject events without raw inputs
      for (i = 0; i < 4; i++) begin
         write_reg(ADDR_MASK, 8'h0e | (8'h10 << i));
         wait_cycles(4);
         check("sim_evt", 32'h10 << i, {24'h0, active_events});
         check("sim_fault", 32'h0, {31'h0, fault_output_n});
      end
      write_reg(ADDR_MASK, 8'h8f);
      wait_cycles(4);
      check("osc_masked", 32'h1, {31'h0, fault_output_n});
      read_check(ADDR_MASK, 8'h8f, "mask_rd");
      write_read(ADDR_MASK, 8'h5a, 8'h5a, "mask_b2b");
      write_reg(ADDR_MASK, 8'h0e);
      wait_cycles(4);
      check("sim_off", 32'h0, {24'h0, active_events});
      // unmapped addresses ignore writes and read zero
      write_reg(8'h20, 8'hff);
      read_check(8'h20, 8'h00, "unmapped");
      read_check(8'h17, 8'h00, "below_map");
      // mid-run reset restores the defaults
      write_reg(ADDR_MASK, 8'h71);
      wait_cycles(2);
      check("pre_rst_fault", 32'h0, {31'h0, fault_output_n});
      srst = 1'b1;
      wait_cycles(2);
      srst = 1'b0;
      read_check(ADDR_MASK, CTL_RST, "mask_rst2");
      read_check(ADDR_CONV, {2'h0, CONV_RST}, "conv_rst2");
      check("fault_rst2", 32'h1, {31'h0, fault_output_n});
      check("conv_cfg2", {26'h0, CONV_RST}, {26'h0, applied_cfg.converter_ctrl_current});
      report_and_stop();
   end

endmodule : laser_driver_general_config_regs_test
